// ---- common/fbo_map.svh ----
`ifndef FBO_MAP_SVH
`define FBO_MAP_SVH
// ==================================================
// Parameter indices within the option menu
`define FBO_IDX_TYPE     6'h01
`define FBO_IDX_VER      6'h02
`define FBO_IDX_NODE     6'h03
`define FBO_IDX_RATE     6'h04
`define FBO_IDX_FMT      6'h05
`define FBO_IDX_DIAG     6'h06
`define FBO_IDX_TRIP     6'h07
`define FBO_IDX_ORDER    6'h08
`define FBO_IDX_IN1      6'h0B
`define FBO_IDX_IN2      6'h0C
`define FBO_IDX_OUT1     6'h15
`define FBO_IDX_OUT2     6'h16
`define FBO_IDX_DFLT     6'h1E
`define FBO_IDX_SUBVER   6'h32
// ==================================================
// Value limits and codes
`define FBO_MAX_BYTE     16'h00FF
`define FBO_MAX_RATE     16'h0009
`define FBO_MAX_4DIG     16'h270F
`define FBO_MAX_MAP      16'h25E3
`define FBO_MAX_SUB      16'h0063
`define FBO_MAX_BIT      16'h0001
`define FBO_DIAG_FAIL    16'hFFFE
`define FBO_DIAG_IDLE    16'hFFFF
`define FBO_RST_VAL      16'h0000
// ==================================================
// Timing
`define FBO_CLK_NS       5
`define FBO_MS_NS        1000000
`define FBO_SEC_NS       1000000000
`define FBO_MS_CYCLES    (`FBO_MS_NS / `FBO_CLK_NS)
`define FBO_SEC_CYCLES   (`FBO_SEC_NS / `FBO_CLK_NS)
`endif

// ---- common/fbo_pkg.sv ----
package fbo_pkg;
    // ==================================================
    // Parameter access request
    typedef struct packed {
        logic        wr;
        logic        priv;
        logic [5:0]  idx;
        logic [15:0] wdata;
    } fbo_acc_t;

    // Identity reported by the fitted option
    typedef struct packed {
        logic [7:0]  type_code;
        logic [15:0] version;
        logic [15:0] subver;
    } fbo_info_t;

    // Configuration seen by the option side
    typedef struct packed {
        logic [7:0]  node;
        logic [3:0]  rate;
        logic [15:0] fmt;
        logic        order_lsb;
        logic [15:0] in_map1;
        logic [15:0] in_map2;
        logic [15:0] out_map1;
        logic [15:0] out_map2;
    } fbo_cfg_t;

    typedef struct packed {
        logic        ch;
        logic [15:0] data;
    } fbo_word_t;

    typedef struct packed {
        logic        ch;
        logic        first;
        logic [7:0]  data;
    } fbo_byte_t;

    typedef enum logic [2:0] {
        FBO_IDLE = 3'b001,
        FBO_HI   = 3'b010,
        FBO_LO   = 3'b100
    } fbo_ser_t;
endpackage

// ---- design/fbo_cyc_word.sv ----
`timescale 1ns/10ps
module fbo_cyc_word
    import fbo_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire logic      rst_b,
    input  wire logic      order_lsb,
    input  wire logic      word_valid,
    output logic           word_ready,
    input  wire fbo_word_t word,
    output fbo_byte_t      tx_byte_q,
    output logic           tx_valid,
    input  wire logic      tx_ready,
    input  wire logic      rx_valid,
    input  wire fbo_byte_t rx_byte,
    output fbo_word_t      rx_word_q,
    output logic           rx_word_valid_q
);
    fbo_ser_t  st_q;
    fbo_ser_t  st_d;
    fbo_word_t hold_q;
    logic [7:0] rx_first_q;
    logic       rx_half_q;
    logic       take;

    // ==================================================
    // Transmit: first byte chosen by order bit
    assign word_ready = (st_q == FBO_IDLE);
    assign tx_valid   = (st_q != FBO_IDLE);
    assign take       = word_valid && word_ready;

    always_comb
    begin
        case (st_q)
            FBO_IDLE: st_d = take ? FBO_HI : FBO_IDLE;
            FBO_HI:   st_d = tx_ready ? FBO_LO : FBO_HI;
            FBO_LO:   st_d = tx_ready ? FBO_IDLE : FBO_LO;
            default:  st_d = FBO_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            st_q      <= FBO_IDLE;
            hold_q    <= '0;
            tx_byte_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            if (take)
            begin
                hold_q    <= word;
                tx_byte_q <= '{word.ch, 1'b1, order_lsb ? word.data[7:0] : word.data[15:8]};
            end
            else if (st_q == FBO_HI && tx_ready)
                tx_byte_q <= '{hold_q.ch, 1'b0, order_lsb ? hold_q.data[15:8] : hold_q.data[7:0]};
        end
    end

    // ==================================================
    // Receive: a first-flagged byte restarts the pairing
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            rx_first_q      <= '0;
            rx_half_q       <= 1'b0;
            rx_word_q       <= '0;
            rx_word_valid_q <= 1'b0;
        end
        else
        begin
            rx_word_valid_q <= rx_valid && !rx_byte.first && rx_half_q;
            if (rx_valid && rx_byte.first)
            begin
                rx_first_q <= rx_byte.data;
                rx_half_q  <= 1'b1;
            end
            else if (rx_valid && rx_half_q)
            begin
                rx_half_q <= 1'b0;
                rx_word_q <= '{rx_byte.ch, order_lsb ? {rx_byte.data, rx_first_q}
                                                     : {rx_first_q, rx_byte.data}};
            end
        end
    end

    a_tx_first_order : assert property (@(posedge ref_clk) disable iff (!rst_b)
        take |=> tx_byte_q.first && tx_byte_q.data == (order_lsb ? hold_q.data[7:0] : hold_q.data[15:8]))
        else $error("first cyclic byte in wrong order");
endmodule

// ---- design/fbo_fifo.sv ----
`timescale 1ns/10ps
module fbo_fifo
    import fbo_pkg::*;
#(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
)
(
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("fbo_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    // ==================================================
    // Pointers carry a wrap bit so full and empty differ
    assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
    assign out_valid = (wr_q != rd_q);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (push)
            mem_q[wr_q[AW-1:0]] <= in_data;
    end
endmodule

// ---- design/fbo_param_bank.sv ----
`timescale 1ns/10ps
`include "fbo_map.svh"
module fbo_param_bank
    import fbo_pkg::*;
#(
    parameter int MS_CYCLES  = `FBO_MS_CYCLES,
    parameter int SEC_CYCLES = `FBO_SEC_CYCLES,
    parameter int FIFO_DEPTH = 8
)
(
    input  wire logic      ref_clk,
    input  wire logic      rst_b,
    input  wire logic      acc_valid,
    output logic           acc_ready,
    input  wire fbo_acc_t  acc,
    output logic [15:0]    rd_data_q,
    output logic           rd_valid_q,
    output logic           acc_err_q,
    input  wire logic      nvm_load_valid,
    input  wire fbo_acc_t  nvm_load,
    output logic           nvm_wr_valid_q,
    output logic [5:0]     nvm_wr_idx_q,
    output logic [15:0]    nvm_wr_data_q,
    input  wire logic      opt_fitted,
    input  wire logic      info_valid,
    input  wire fbo_info_t info,
    input  wire logic      init_fail,
    input  wire logic      net_running,
    input  wire logic      net_cycle,
    input  wire logic      comms_frame,
    output logic           comms_trip_q,
    output fbo_cfg_t       cfg,
    input  wire logic      out_valid,
    output logic           out_ready,
    input  wire fbo_word_t out_word,
    output fbo_byte_t      tx_byte_q,
    output logic           tx_valid,
    input  wire logic      tx_ready,
    input  wire logic      rx_valid,
    input  wire fbo_byte_t rx_byte,
    output fbo_word_t      in_word_q,
    output logic           in_valid_q
);
    initial
    begin
        if (MS_CYCLES < 1 || SEC_CYCLES < 1 || FIFO_DEPTH < 2)
            $error("fbo_param_bank timing or depth parameter out of range");
    end

    // ==================================================
    // Access arbitration and decode
    logic [15:0] bank_q [64];
    fbo_acc_t    src;
    logic        take;
    logic        mapped;
    logic        ro_entry;
    logic        ro_block;
    logic        in_range;
    logic        we;
    logic        stored;
    logic        dflt_go;
    logic        sec_end;
    logic [15:0] diag_d;
    logic [15:0] ver_clip;
    logic [15:0] sub_clip;

    // Restore from nonvolatile memory wins; the bank itself never stalls otherwise
    assign acc_ready = !nvm_load_valid;
    assign src       = nvm_load_valid ? nvm_load : acc;
    assign take      = nvm_load_valid || acc_valid;

    assign mapped   = (src.idx == `FBO_IDX_TYPE) || (src.idx == `FBO_IDX_VER) || (src.idx == `FBO_IDX_NODE)
                   || (src.idx == `FBO_IDX_RATE) || (src.idx == `FBO_IDX_FMT) || (src.idx == `FBO_IDX_DIAG)
                   || (src.idx == `FBO_IDX_TRIP) || (src.idx == `FBO_IDX_ORDER) || (src.idx == `FBO_IDX_IN1)
                   || (src.idx == `FBO_IDX_IN2) || (src.idx == `FBO_IDX_OUT1) || (src.idx == `FBO_IDX_OUT2)
                   || (src.idx == `FBO_IDX_DFLT) || (src.idx == `FBO_IDX_SUBVER);
    assign ro_entry = (src.idx == `FBO_IDX_TYPE) || (src.idx == `FBO_IDX_VER)
                   || (src.idx == `FBO_IDX_DIAG) || (src.idx == `FBO_IDX_SUBVER);
    assign ro_block = !nvm_load_valid && src.priv && ro_entry;

    assign in_range = (src.idx == `FBO_IDX_TYPE)   ? (src.wdata <= `FBO_MAX_BYTE) :
                      (src.idx == `FBO_IDX_NODE)   ? (src.wdata <= `FBO_MAX_BYTE) :
                      (src.idx == `FBO_IDX_RATE)   ? (src.wdata <= `FBO_MAX_RATE) :
                      (src.idx == `FBO_IDX_FMT)    ? (src.wdata <= `FBO_MAX_4DIG) :
                      (src.idx == `FBO_IDX_VER)    ? (src.wdata <= `FBO_MAX_4DIG) :
                      (src.idx == `FBO_IDX_TRIP)   ? (src.wdata <= `FBO_MAX_4DIG) :
                      (src.idx == `FBO_IDX_ORDER)  ? (src.wdata <= `FBO_MAX_BIT)  :
                      (src.idx == `FBO_IDX_DFLT)   ? (src.wdata <= `FBO_MAX_BIT)  :
                      (src.idx == `FBO_IDX_SUBVER) ? (src.wdata <= `FBO_MAX_SUB)  :
                      (src.idx == `FBO_IDX_DIAG)   ? 1'b1 :
                      (src.wdata <= `FBO_MAX_MAP);

    assign we      = take && src.wr && mapped && in_range && !ro_block;
    // Diagnostic is live status and the load command is one-shot, so neither is kept
    assign stored  = (src.idx != `FBO_IDX_DIAG) && (src.idx != `FBO_IDX_DFLT);
    assign dflt_go = (bank_q[`FBO_IDX_DFLT] != `FBO_RST_VAL);

    // Reported version in hundredths; values beyond four digits are clipped
    assign ver_clip = (info.version > `FBO_MAX_4DIG) ? `FBO_MAX_4DIG : info.version;
    assign sub_clip = (info.subver > `FBO_MAX_SUB) ? `FBO_MAX_SUB : info.subver;

    // ==================================================
    // Parameter storage, one flip-flop word per index
    generate
        for (genvar i = 0; i < 64; i++)
        begin : g_entry
            localparam logic [5:0] IDX = 6'(i);
            logic        hw_we;
            logic [15:0] hw_val;
            logic        rw_entry;

            assign rw_entry = (IDX != `FBO_IDX_TYPE) && (IDX != `FBO_IDX_VER)
                           && (IDX != `FBO_IDX_DIAG) && (IDX != `FBO_IDX_SUBVER);
            assign hw_we  = ((IDX == `FBO_IDX_TYPE) || (IDX == `FBO_IDX_VER) || (IDX == `FBO_IDX_SUBVER))
                            ? info_valid : (IDX == `FBO_IDX_DIAG) ? sec_end : 1'b0;
            assign hw_val = (IDX == `FBO_IDX_TYPE) ? {8'h00, info.type_code} :
                            (IDX == `FBO_IDX_VER)  ? ver_clip :
                            (IDX == `FBO_IDX_DIAG) ? diag_d : sub_clip;

            always_ff @(posedge ref_clk)
            begin
                if (!rst_b)
                    bank_q[i] <= `FBO_RST_VAL;
                else if (dflt_go && rw_entry)
                    bank_q[i] <= `FBO_RST_VAL;
                else if (hw_we)
                    bank_q[i] <= hw_val;
                else if (we && src.idx == IDX)
                    bank_q[i] <= src.wdata;
            end
        end
    endgenerate

    // ==================================================
    // Read answers, errors and nonvolatile write-back
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            rd_data_q      <= '0;
            rd_valid_q     <= 1'b0;
            acc_err_q      <= 1'b0;
            nvm_wr_valid_q <= 1'b0;
            nvm_wr_idx_q   <= '0;
            nvm_wr_data_q  <= '0;
        end
        else
        begin
            rd_valid_q     <= acc_valid && acc_ready && !acc.wr;
            rd_data_q      <= bank_q[acc.idx];
            acc_err_q      <= acc_valid && acc_ready && !(acc.wr ? we : mapped);
            nvm_wr_valid_q <= we && !nvm_load_valid && stored;
            nvm_wr_idx_q   <= src.idx;
            nvm_wr_data_q  <= src.wdata;
        end
    end

    // ==================================================
    // Network cycles per second
    logic [31:0] sec_cnt_q;
    logic [13:0] cyc_cnt_q;

    assign sec_end = (sec_cnt_q == 32'(SEC_CYCLES - 1));
    assign diag_d  = init_fail    ? `FBO_DIAG_FAIL :
                     !net_running ? `FBO_DIAG_IDLE : {2'b00, cyc_cnt_q};

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            sec_cnt_q <= '0;
            cyc_cnt_q <= '0;
        end
        else
        begin
            sec_cnt_q <= sec_end ? '0 : sec_cnt_q + 32'h0000_0001;
            if (sec_end)
                cyc_cnt_q <= 14'(net_cycle);
            else if (net_cycle && {2'b00, cyc_cnt_q} < `FBO_MAX_4DIG)
                cyc_cnt_q <= cyc_cnt_q + 14'h0001;
        end
    end

    // ==================================================
    // Communications-loss trip timer
    logic [31:0] ms_cnt_q;
    logic [15:0] loss_ms_q;
    logic        ms_tick;
    logic [15:0] trip_ms;

    assign trip_ms = bank_q[`FBO_IDX_TRIP];
    assign ms_tick = (ms_cnt_q == 32'(MS_CYCLES - 1));

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            ms_cnt_q     <= '0;
            loss_ms_q    <= '0;
            comms_trip_q <= 1'b0;
        end
        else
        begin
            ms_cnt_q <= (ms_tick || comms_frame) ? '0 : ms_cnt_q + 32'h0000_0001;
            if (comms_frame)
                loss_ms_q <= '0;
            else if (ms_tick && loss_ms_q < `FBO_MAX_4DIG)
                loss_ms_q <= loss_ms_q + 16'h0001;
            if (comms_frame || trip_ms == `FBO_RST_VAL)
                comms_trip_q <= 1'b0;
            else if (loss_ms_q >= trip_ms)
                comms_trip_q <= 1'b1;
        end
    end

    // ==================================================
    // Configuration and cyclic data path
    assign cfg = '{bank_q[`FBO_IDX_NODE][7:0], bank_q[`FBO_IDX_RATE][3:0], bank_q[`FBO_IDX_FMT],
                   bank_q[`FBO_IDX_ORDER][0], bank_q[`FBO_IDX_IN1], bank_q[`FBO_IDX_IN2],
                   bank_q[`FBO_IDX_OUT1], bank_q[`FBO_IDX_OUT2]};

    logic      out_en;
    logic      fifo_in_ready;
    logic      fifo_out_valid;
    logic      ser_ready;
    fbo_word_t fifo_word;
    fbo_word_t rx_word;
    logic      rx_word_valid;

    // Words for an unmapped channel are swallowed rather than queued
    assign out_en    = (out_word.ch ? cfg.out_map2 : cfg.out_map1) != `FBO_RST_VAL;
    assign out_ready = fifo_in_ready || !out_en;

    fbo_fifo #(.WIDTH($bits(fbo_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .in_valid  (out_valid && out_en),
        .in_ready  (fifo_in_ready),
        .in_data   (out_word),
        .out_valid (fifo_out_valid),
        .out_ready (ser_ready),
        .out_data  (fifo_word)
    );

    fbo_cyc_word u_cyc (
        .ref_clk         (ref_clk),
        .rst_b           (rst_b),
        .order_lsb       (cfg.order_lsb),
        .word_valid      (fifo_out_valid),
        .word_ready      (ser_ready),
        .word            (fifo_word),
        .tx_byte_q       (tx_byte_q),
        .tx_valid        (tx_valid),
        .tx_ready        (tx_ready),
        .rx_valid        (rx_valid),
        .rx_byte         (rx_byte),
        .rx_word_q       (rx_word),
        .rx_word_valid_q (rx_word_valid)
    );

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            in_word_q  <= '0;
            in_valid_q <= 1'b0;
        end
        else
        begin
            in_valid_q <= rx_word_valid && ((rx_word.ch ? cfg.in_map2 : cfg.in_map1) != `FBO_RST_VAL);
            in_word_q  <= rx_word;
        end
    end

    // ==================================================
    // Checks
    a_ro_priv_write : assert property (@(posedge ref_clk) disable iff (!rst_b)
        (acc_valid && !nvm_load_valid && acc.wr && acc.priv && acc.idx == `FBO_IDX_TYPE && !info_valid)
        |=> $stable(bank_q[`FBO_IDX_TYPE]) && acc_err_q)
        else $error("privileged write changed a read-only entry");
    a_third_write : assert property (@(posedge ref_clk) disable iff (!rst_b)
        (acc_valid && !nvm_load_valid && acc.wr && !acc.priv && acc.idx == `FBO_IDX_SUBVER
         && acc.wdata <= `FBO_MAX_SUB && !info_valid && !dflt_go)
        |=> bank_q[`FBO_IDX_SUBVER] == $past(acc.wdata))
        else $error("unprivileged write to sub-version lost");
    a_nvm_store : assert property (@(posedge ref_clk) disable iff (!rst_b)
        (acc_valid && !nvm_load_valid && acc.wr && acc.idx == `FBO_IDX_NODE
         && acc.wdata <= `FBO_MAX_BYTE) |=> nvm_wr_valid_q && nvm_wr_idx_q == `FBO_IDX_NODE)
        else $error("node address write not stored");
    a_ready_always : assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!nvm_load_valid && !opt_fitted) |-> acc_ready)
        else $error("bank refused access without option");
    a_ver_range : assert property (@(posedge ref_clk) disable iff (!rst_b)
        info_valid |=> bank_q[`FBO_IDX_VER] <= `FBO_MAX_4DIG)
        else $error("version beyond four digits");
    a_sub_range : assert property (@(posedge ref_clk) disable iff (!rst_b)
        info_valid |=> bank_q[`FBO_IDX_SUBVER] <= `FBO_MAX_SUB)
        else $error("sub-version beyond 99");
    a_rate_range : assert property (@(posedge ref_clk) disable iff (!rst_b)
        bank_q[`FBO_IDX_RATE] <= `FBO_MAX_RATE)
        else $error("link rate code beyond 9");
    a_fmt_range : assert property (@(posedge ref_clk) disable iff (!rst_b)
        bank_q[`FBO_IDX_FMT] <= `FBO_MAX_4DIG)
        else $error("format setting beyond 99.99");
    a_diag_fail : assert property (@(posedge ref_clk) disable iff (!rst_b)
        (sec_end && init_fail) |=> bank_q[`FBO_IDX_DIAG] == `FBO_DIAG_FAIL)
        else $error("diagnostic missed init failure");
    a_trip_off : assert property (@(posedge ref_clk) disable iff (!rst_b)
        (trip_ms == `FBO_RST_VAL) |=> !comms_trip_q)
        else $error("trip raised while disabled");
    a_map_range : assert property (@(posedge ref_clk) disable iff (!rst_b)
        (cfg.in_map1 <= `FBO_MAX_MAP) && (cfg.out_map2 <= `FBO_MAX_MAP))
        else $error("cyclic map beyond 96.99");
endmodule

// ---- sim/fbo_opt_model.sv ----
`timescale 1ns/10ps
module fbo_opt_model
    import fbo_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire logic      rst_b,
    input  wire logic      frames_on,
    input  wire logic      tx_valid,
    input  wire fbo_byte_t tx_byte_q,
    output logic           tx_ready,
    output logic           net_cycle,
    output logic           comms_frame,
    output logic           rx_valid,
    output fbo_byte_t      rx_byte
);
    logic [2:0] cnt_q;
    logic       take;
    // Stall every other cycle so byte holding is exercised
    assign tx_ready    = cnt_q[0];
    assign take        = tx_valid && tx_ready;
    assign net_cycle   = (cnt_q == 3'h0);
    assign comms_frame = frames_on && (cnt_q == 3'h3);
    // Echo each byte back; an idle line flips so stale data never looks valid
    always_ff @(posedge ref_clk)
    begin
        cnt_q    <= rst_b ? cnt_q + 3'h1 : 3'h0;
        rx_valid <= rst_b && take;
        rx_byte  <= (take || !rst_b) ? tx_byte_q : ~rx_byte;
    end
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/10ps
module tb
    import fbo_pkg::*;
;
    logic        ref_clk = 1'b0, rst_b = 1'b0, acc_valid = 1'b0, info_valid = 1'b0;
    logic        init_fail = 1'b0, net_running = 1'b0, frames_on = 1'b1, out_valid = 1'b0;
    logic        nvm_load_valid = 1'b0, opt_fitted = 1'b0;
    fbo_acc_t    acc = '0, nvm_load = '0;
    fbo_cfg_t    cfg;
    fbo_info_t   info = '0;
    fbo_word_t   out_word = '0, in_word_q;
    fbo_byte_t   tx_byte_q, rx_byte;
    logic [15:0] rd_data_q, nvm_wr_data_q, first_b, got_w;
    logic [5:0]  nvm_wr_idx_q;
    logic        acc_ready, rd_valid_q, acc_err_q, nvm_wr_valid_q, comms_trip_q, out_ready;
    logic        tx_valid, tx_ready, rx_valid, net_cycle, comms_frame, in_valid_q;
    int          mismatches = 0, tests_run = 0, cyc = 0;
    logic [5:0]  rst_idx [15] = '{1, 2, 3, 4, 5, 6, 7, 8, 6'h0B, 6'h0C, 6'h15, 6'h16, 6'h1E, 6'h32, 6'h09};
    logic [5:0]  lim_idx [9] = '{3, 4, 5, 7, 8, 6'h0B, 6'h0C, 6'h15, 6'h16};
    logic [15:0] lim_val [9] = '{16'h00FF, 16'h0009, 16'h270F, 16'h270F, 16'h0001,
                                 16'h25E3, 16'h25E3, 16'h25E3, 16'h25E3};

    // Second window spans a whole number of partner cycles, so the rate reads steady
    fbo_param_bank #(.MS_CYCLES(4), .SEC_CYCLES(48), .FIFO_DEPTH(8)) uut (
        .ref_clk, .rst_b, .acc_valid, .acc_ready, .acc, .rd_data_q, .rd_valid_q, .acc_err_q,
        .nvm_load_valid, .nvm_load, .nvm_wr_valid_q, .nvm_wr_idx_q, .nvm_wr_data_q,
        .opt_fitted, .info_valid, .info, .init_fail, .net_running, .net_cycle, .comms_frame,
        .comms_trip_q, .cfg, .out_valid, .out_ready, .out_word, .tx_byte_q, .tx_valid, .tx_ready,
        .rx_valid, .rx_byte, .in_word_q, .in_valid_q);
    fbo_opt_model opt (.ref_clk, .rst_b, .frames_on, .tx_valid, .tx_byte_q, .tx_ready, .net_cycle,
        .comms_frame, .rx_valid, .rx_byte);

    always #2.5 ref_clk = ~ref_clk;

    // ==================================================
    // Monitors and hang guard
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (tx_valid && tx_ready && tx_byte_q.first)
            first_b <= {8'h00, tx_byte_q.data};
        if (in_valid_q)
            got_w <= in_word_q.data;
        if (cyc == 20000)
        begin
            mismatches = mismatches + 1;
            final_report();
        end
    end

    // ==================================================
    // Tasks
    task automatic final_report();
        if (mismatches == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One access; answer and store request are looked at one cycle after it is taken
    task automatic xfer(input logic wr, input logic pr, input logic [5:0] idx, input logic [15:0] wd,
                        input logic [15:0] exp, input logic err);
        logic st;
        st = wr && !err && idx != 6'h1E;
        @(posedge ref_clk);
        acc_valid <= 1'b1;
        acc <= '{wr, pr, idx, wd};
        do @(posedge ref_clk); while (!acc_ready);
        acc_valid <= 1'b0;
        #1;
        chk("acc_err_q", {15'h0000, err}, {15'h0000, acc_err_q});
        chk("rd_valid_q", {15'h0000, !wr}, {15'h0000, rd_valid_q});
        if (!wr)
            chk("rd_data_q", exp, rd_data_q);
        chk("nvm_wr_valid_q", {15'h0000, st}, {15'h0000, nvm_wr_valid_q});
        if (st)
        begin
            chk("nvm_wr_data_q", wd, nvm_wr_data_q);
            chk("nvm_wr_idx_q", {10'h000, idx}, {10'h000, nvm_wr_idx_q});
        end
    endtask

    // One cyclic word offered until taken, then time for the echo to return
    task automatic send(input fbo_word_t w);
        @(posedge ref_clk);
        out_word <= w;
        out_valid <= 1'b1;
        do @(posedge ref_clk); while (!out_ready);
        out_valid <= 1'b0;
        repeat (20) @(posedge ref_clk);
    endtask

    // ==================================================
    // Sequence
    initial
    begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        foreach (rst_idx[i])
            xfer(0, 0, rst_idx[i], 0, 16'h0000, i == 14);
        @(posedge ref_clk);
        info <= '{8'h05, 16'h012E, 16'h0001};
        info_valid <= 1'b1;
        opt_fitted <= 1'b1;
        @(posedge ref_clk);
        info_valid <= 1'b0;
        xfer(0, 0, 6'h02, 0, 16'h012E, 0);
        xfer(1, 0, 6'h02, 16'h2710, 0, 1);
        xfer(1, 1, 6'h01, 16'h0007, 0, 1);
        xfer(0, 1, 6'h01, 0, 16'h0005, 0);
        xfer(1, 1, 6'h32, 16'h0005, 0, 1);
        xfer(1, 0, 6'h32, 16'h0064, 0, 1);
        xfer(1, 0, 6'h32, 16'h0063, 0, 0);
        xfer(0, 0, 6'h32, 0, 16'h0063, 0);
        foreach (lim_idx[i])
        begin
            xfer(1, 1, lim_idx[i], lim_val[i], 0, 0);
            xfer(1, 1, lim_idx[i], lim_val[i] + 16'h0001, 0, 1);
            xfer(0, 1, lim_idx[i], 0, lim_val[i], 0);
        end
        chk("cfg_out_map2", 16'h25E3, cfg.out_map2);
        // Distinct words per pass so a missed capture cannot pass on stale data
        for (int o = 1; o >= 0; o--)
        begin
            xfer(1, 0, 6'h08, o[15:0], 0, 0);
            send('{o == 0, o ? 16'h1234 : 16'hABCD});
            chk("first_byte", o ? 16'h0034 : 16'h00AB, first_b);
            chk("in_word_q", o ? 16'h1234 : 16'hABCD, got_w);
        end
        xfer(1, 0, 6'h07, 16'h0003, 0, 0);
        repeat (30) @(posedge ref_clk);
        #1 chk("trip_with_frames", 0, {15'h0000, comms_trip_q});
        @(posedge ref_clk);
        frames_on <= 1'b0;
        repeat (30) @(posedge ref_clk);
        #1 chk("trip_lost", 1, {15'h0000, comms_trip_q});
        xfer(1, 0, 6'h07, 0, 0, 0);
        @(posedge ref_clk);
        #1 chk("trip_disabled", 0, {15'h0000, comms_trip_q});
        @(posedge ref_clk);
        init_fail <= 1'b1;
        repeat (110) @(posedge ref_clk);
        xfer(0, 0, 6'h06, 0, 16'hFFFE, 0);
        @(posedge ref_clk);
        init_fail <= 1'b0;
        repeat (110) @(posedge ref_clk);
        xfer(0, 0, 6'h06, 0, 16'hFFFF, 0);
        @(posedge ref_clk);
        net_running <= 1'b1;
        repeat (110) @(posedge ref_clk);
        xfer(0, 0, 6'h06, 0, 16'h0006, 0);
        xfer(1, 0, 6'h1E, 16'h0001, 0, 0);
        xfer(0, 0, 6'h03, 0, 16'h0000, 0);
        xfer(0, 0, 6'h1E, 0, 16'h0000, 0);
        xfer(0, 0, 6'h01, 0, 16'h0005, 0);
        send('{1'b1, 16'h5A5A});
        chk("unmapped_tx", 16'h00AB, first_b);
        chk("unmapped_in", 16'hABCD, got_w);
        @(posedge ref_clk);
        nvm_load <= '{1'b1, 1'b1, 6'h02, 16'h0100};
        nvm_load_valid <= 1'b1;
        #1 chk("acc_ready", 0, {15'h0000, acc_ready});
        @(posedge ref_clk);
        nvm_load_valid <= 1'b0;
        #1 chk("nvm_wr_valid_q", 0, {15'h0000, nvm_wr_valid_q});
        xfer(0, 1, 6'h02, 0, 16'h0100, 0);
        final_report();
    end
endmodule
